// ===== hdl/dspm_top.sv
/*
  Multiplier block: 9/18/36-bit multipliers, adders, accumulator,
  output mux and optional output registers, configured over AXI4-Lite.
  Assumes operands and controls come from fabric logic on sys_clk.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dspm_top (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic [dspm_pkg::ADDRW-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [dspm_pkg::ADDRW-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [dspm_pkg::OPW-1:0]    op_a,
  input  wire logic [dspm_pkg::OPW-1:0]    op_b,
  input  wire logic                        sign_a,
  input  wire logic                        sign_b,
  input  wire logic                        add_nsub,
  input  wire logic                        acc_clr,
  input  wire logic [dspm_pkg::NSET-1:0]   out_ena,
  input  wire logic [dspm_pkg::NSET-1:0]   out_clr,
  output logic [dspm_pkg::RESW-1:0]        result,
  output logic                             cfg_err
);
  localparam int W9   = dspm_pkg::W9;
  localparam int W18  = dspm_pkg::W18;
  localparam int W36  = dspm_pkg::W36;
  localparam int EXTW = dspm_pkg::EXTW;
  localparam int ACCW = dspm_pkg::ACCW;
  localparam int RESW = dspm_pkg::RESW;
  localparam int GRPW = dspm_pkg::GRPW;

  logic [dspm_pkg::CTRLW-1:0] ctrl_q;
  dspm_pkg::dspm_ctrl_t       ctrl;
  assign ctrl = dspm_pkg::dspm_ctrl_t'(ctrl_q);

  // AXI4-Lite slave: address and data taken in either order
  logic                       aw_got;
  logic                       w_got;
  logic [dspm_pkg::ADDRW-1:0] aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       do_wr;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr         = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      aw_got  <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got  <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_got  <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      w_got  <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got  <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_wr) begin
      w_got  <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dspm_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == dspm_pkg::REG_CTRL) ?
                      dspm_pkg::RESP_OKAY : dspm_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] strb_mask;
  logic [31:0] next_ctrl;
  assign strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                      {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign next_ctrl = (w_data & strb_mask) |
                     ({14'h0000, ctrl_q} & ~strb_mask);

  // the whole block takes one mode from this register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_q <= dspm_pkg::CTRL_RST;
    end else if (do_wr && aw_addr == dspm_pkg::REG_CTRL) begin
      ctrl_q <= next_ctrl[dspm_pkg::CTRLW-1:0];
    end
  end

  // operand signs: fixed, or dynamic from the sign pins
  logic sa;
  logic sb;
  logic dyn_b;
  logic psgn;
  assign dyn_b = ctrl.shared_sign ? sign_a : sign_b;
  assign sa = (ctrl.sgn_a == dspm_pkg::SG_SGN) ||
              (ctrl.sgn_a == dspm_pkg::SG_DYN && sign_a);
  assign sb = (ctrl.sgn_b == dspm_pkg::SG_SGN) ||
              (ctrl.sgn_b == dspm_pkg::SG_DYN && dyn_b);
  assign psgn = sa || sb;

  // 36-bit operand trimming for mixed and dynamic signs
  logic a_uns;
  logic a_dyn;
  logic b_uns;
  logic b_dyn;
  logic lim_a;
  logic lim_b;
  logic is36;
  assign a_uns = ctrl.sgn_a == dspm_pkg::SG_UNS;
  assign a_dyn = ctrl.sgn_a == dspm_pkg::SG_DYN;
  assign b_uns = ctrl.sgn_b == dspm_pkg::SG_UNS;
  assign b_dyn = ctrl.sgn_b == dspm_pkg::SG_DYN;
  assign is36  = ctrl.size == dspm_pkg::SZ_36;
  // matched fixed signs keep all 36 bits
  assign lim_a = is36 && (
      (a_uns && !b_uns) ||
      (a_dyn && ctrl.sgn_b == dspm_pkg::SG_SGN) ||
      (a_dyn && b_dyn && !ctrl.shared_sign));
  assign lim_b = is36 && (
      (b_uns && !a_uns) ||
      (b_dyn && ctrl.sgn_a == dspm_pkg::SG_SGN) ||
      (b_dyn && a_dyn && !ctrl.shared_sign));

  logic [W36-1:0] a36;
  logic [W36-1:0] b36;
  // a trimmed operand keeps 35 bits; bit 35 repeats bit 34 when signed
  assign a36 = lim_a ? {sa & op_a[W36-2], op_a[W36-2:0]} : op_a[W36-1:0];
  assign b36 = lim_b ? {sb & op_b[W36-2], op_b[W36-2:0]} : op_b[W36-1:0];

  // multiplier array, products at full width
  logic [dspm_pkg::N9-1:0][2*W9-1:0]   p9;
  logic [dspm_pkg::N18-1:0][2*W18-1:0] p18;
  logic [2*W36-1:0]                    p36;
  logic [dspm_pkg::N9-1:0][EXTW-1:0]   e9;
  logic [dspm_pkg::N18-1:0][EXTW-1:0]  e18;

  for (genvar i = 0; i < dspm_pkg::N9; i++) begin : m9
    dspm_mul #(.W(W9)) u_mul (
      .a  (op_a[i*W9 +: W9]),
      .b  (op_b[i*W9 +: W9]),
      .sa (sa),
      .sb (sb),
      .p  (p9[i])
    );
    assign e9[i] = {{(EXTW-2*W9){psgn & p9[i][2*W9-1]}}, p9[i]};
  end

  for (genvar i = 0; i < dspm_pkg::N18; i++) begin : m18
    dspm_mul #(.W(W18)) u_mul (
      .a  (op_a[i*W18 +: W18]),
      .b  (op_b[i*W18 +: W18]),
      .sa (sa),
      .sb (sb),
      .p  (p18[i])
    );
    assign e18[i] = {{(EXTW-2*W18){psgn & p18[i][2*W18-1]}}, p18[i]};
  end

  dspm_mul #(.W(W36)) u_m36 (
    .a  (a36),
    .b  (b36),
    .sa (sa),
    .sb (sb),
    .p  (p36)
  );

  // second product of each pair is added or subtracted
  function automatic logic [EXTW-1:0] pair(
    input logic [EXTW-1:0] x,
    input logic [EXTW-1:0] y,
    input logic            add
  );
    pair = add ? x + y : x - y;
  endfunction : pair

  // accumulator, fed by the first 9x9 or 18x18 product
  logic [ACCW-1:0] acc;
  logic [ACCW-1:0] acc_base;
  logic [ACCW-1:0] acc_in;
  assign acc_base = acc_clr ? '0 : acc;
  assign acc_in   = (ctrl.size == dspm_pkg::SZ_9) ?
                    e9[0][ACCW-1:0] : e18[0][ACCW-1:0];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      acc <= '0;
    end else if (ctrl.mode == dspm_pkg::MODE_MAC && !cfg_err) begin
      acc <= add_nsub ? acc_base + acc_in : acc_base - acc_in;
    end
  end

  // illegal codes, and 36-bit size outside simple mode, are refused
  always_comb begin
    cfg_err = 1'b0;
    if (ctrl.size == 2'h3 || ctrl.sgn_a == 2'h3 || ctrl.sgn_b == 2'h3) begin
      cfg_err = 1'b1;
    end else if (is36 && ctrl.mode != dspm_pkg::MODE_SIMPLE) begin
      cfg_err = 1'b1;
    end
  end

  // output selection multiplexer
  logic [RESW-1:0] sel;
  logic [EXTW-1:0] s_a;
  logic [EXTW-1:0] s_b;
  logic [EXTW-1:0] s_c;
  logic [EXTW-1:0] s_d;

  always_comb begin
    sel = '0;
    s_a = '0;
    s_b = '0;
    s_c = '0;
    s_d = '0;
    if (!cfg_err) begin
      unique case (ctrl.mode)
        dspm_pkg::MODE_SIMPLE: begin
          // products go straight out, one per lane
          if (ctrl.size == dspm_pkg::SZ_9) begin
            sel = p9;
          end else if (ctrl.size == dspm_pkg::SZ_18) begin
            sel = p18;
          end else begin
            sel = {{(RESW-2*W36){1'b0}}, p36};
          end
        end
        dspm_pkg::MODE_MAC: begin
          sel = {{(RESW-ACCW){psgn & acc[ACCW-1]}}, acc};
        end
        dspm_pkg::MODE_ADD2: begin
          if (ctrl.size == dspm_pkg::SZ_9) begin
            s_a = pair(e9[0], e9[1], add_nsub);
            s_b = pair(e9[2], e9[3], add_nsub);
            s_c = pair(e9[4], e9[5], add_nsub);
            s_d = pair(e9[6], e9[7], add_nsub);
            sel = {s_d[GRPW-1:0], s_c[GRPW-1:0],
                   s_b[GRPW-1:0], s_a[GRPW-1:0]};
          end else begin
            s_a = pair(e18[0], e18[1], add_nsub);
            s_b = pair(e18[2], e18[3], add_nsub);
            sel = {s_b, s_a};
          end
        end
        dspm_pkg::MODE_ADD4: begin
          if (ctrl.size == dspm_pkg::SZ_9) begin
            s_a = pair(e9[0], e9[1], add_nsub) +
                  pair(e9[2], e9[3], add_nsub);
            s_b = pair(e9[4], e9[5], add_nsub) +
                  pair(e9[6], e9[7], add_nsub);
            sel = {s_b, s_a};
          end else begin
            s_a = pair(e18[0], e18[1], add_nsub) +
                  pair(e18[2], e18[3], add_nsub);
            sel = {{(RESW-EXTW){psgn & s_a[EXTW-1]}}, s_a};
          end
        end
      endcase
    end
  end

  dspm_res_if res_if ();
  assign res_if.data    = sel;
  assign res_if.grp_set = ctrl.grp_set;
  assign res_if.bypass  = !ctrl.outreg_en;

  dspm_outreg u_outreg (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set_ena (out_ena),
    .set_clr (out_clr),
    .res     (res_if.dst),
    .q       (result)
  );

  // read side: one cycle from address to data
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      dspm_pkg::REG_CTRL: rd_word = {14'h0000, ctrl_q};
      dspm_pkg::REG_STAT: rd_word = {30'h0000_0000, psgn, cfg_err};
      dspm_pkg::REG_RES0: rd_word = result[31:0];
      dspm_pkg::REG_RES1: rd_word = result[63:32];
      dspm_pkg::REG_ACC0: rd_word = acc[31:0];
      default:            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= dspm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? dspm_pkg::RESP_OKAY : dspm_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : dspm_top

// ===== hdl/dspm_pkg.sv
/*
  Shared constants and types of the multiplier block: register map,
  control-field layout, mode/size/sign encodings and datapath widths.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package dspm_pkg;

  localparam int ADDRW = 8;
  localparam logic [ADDRW-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDRW-1:0] REG_STAT = 8'h04;
  localparam logic [ADDRW-1:0] REG_RES0 = 8'h08;
  localparam logic [ADDRW-1:0] REG_RES1 = 8'h0C;
  localparam logic [ADDRW-1:0] REG_ACC0 = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam int W9    = 9;
  localparam int W18   = 18;
  localparam int W36   = 36;
  localparam int N9    = 8;
  localparam int N18   = 4;
  localparam int OPW   = 72;
  localparam int EXTW  = 72;
  localparam int RESW  = 144;
  localparam int NSET  = 4;
  localparam int GRPW  = 36;
  localparam int ACCW  = 52;
  localparam int CTRLW = 18;

  typedef enum logic [1:0] {
    MODE_SIMPLE, MODE_MAC, MODE_ADD2, MODE_ADD4
  } dspm_mode_t;
  typedef enum logic [1:0] {SZ_9, SZ_18, SZ_36} dspm_size_t;
  typedef enum logic [1:0] {SG_UNS, SG_SGN, SG_DYN} dspm_sgn_t;

  // control register, lsb first from the bottom of the list
  typedef struct packed {
    logic [NSET-1:0][1:0] grp_set;
    logic                 outreg_en;
    logic                 shared_sign;
    dspm_sgn_t            sgn_b;
    dspm_sgn_t            sgn_a;
    dspm_size_t           size;
    dspm_mode_t           mode;
  } dspm_ctrl_t;

  localparam logic [CTRLW-1:0] CTRL_RST = 18'h0_0000;

endpackage : dspm_pkg

// ===== hdl/dspm_res_if.sv
/*
  Carrier between the arithmetic core and the output register bank:
  selected result, per-group control-set choice and bypass.
  Assumes both ends sit on sys_clk.
*/
`timescale 1ns/1ps
interface dspm_res_if;
  logic [dspm_pkg::RESW-1:0]       data;
  logic [dspm_pkg::NSET-1:0][1:0]  grp_set;
  logic                            bypass;
  modport src (output data, output grp_set, output bypass);
  modport dst (input data, input grp_set, input bypass);
endinterface : dspm_res_if

// ===== hdl/dspm_mul.sv
/*
  One W x W multiplier with per-operand sign flags.
  Assumes operands already trimmed to the legal width by the caller.
*/
`timescale 1ns/1ps
module dspm_mul #(
  parameter int W = 9
) (
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  input  wire logic           sa,
  input  wire logic           sb,
  output logic      [2*W-1:0] p
);
  logic signed [W:0]     ea;
  logic signed [W:0]     eb;
  logic signed [2*W+1:0] full;

  assign ea   = {sa & a[W-1], a};
  assign eb   = {sb & b[W-1], b};
  assign full = ea * eb;
  // low 2W bits hold every product exactly, signed or not
  assign p    = full[2*W-1:0];
endmodule : dspm_mul

// ===== hdl/dspm_outreg.sv
/*
  Optional output registers in four groups; each group follows one of
  four clear/enable sets. Assumes clears and enables from same-clock
  fabric logic.
*/
`timescale 1ns/1ps
module dspm_outreg (
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire logic [dspm_pkg::NSET-1:0] set_ena,
  input  wire logic [dspm_pkg::NSET-1:0] set_clr,
  dspm_res_if.dst                       res,
  output logic [dspm_pkg::RESW-1:0]     q
);
  localparam int G = dspm_pkg::GRPW;

  for (genvar g = 0; g < dspm_pkg::NSET; g++) begin : grp
    logic [G-1:0] r;
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        r <= '0;
      end else if (set_clr[res.grp_set[g]]) begin
        r <= '0;
      end else if (set_ena[res.grp_set[g]]) begin
        r <= res.data[g*G +: G];
      end
    end
    // bypass is combinational so the unregistered path keeps no latency
    assign q[g*G +: G] = res.bypass ? res.data[g*G +: G] : r;
  end
endmodule : dspm_outreg

// ===== testbench/dspm_fabric.sv
/*
  Fabric-side model: drives operands, sign and accumulate controls and
  the output-register clear/enable sets of the multiplier block.
  Assumes every call starts just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module dspm_fabric (
  input  wire logic        sys_clk,
  output logic      [71:0] op_a,
  output logic      [71:0] op_b,
  output logic             sign_a,
  output logic             sign_b,
  output logic             add_nsub,
  output logic             acc_clr,
  output logic      [3:0]  out_ena,
  output logic      [3:0]  out_clr
);
  initial begin
    {op_a, op_b, sign_a, sign_b, add_nsub, acc_clr, out_ena, out_clr} = '0;
  end

  // one operand set per cycle, all for the single configured mode
  task automatic ops(input logic [71:0] a, b, input logic sa, sb);
    @(posedge sys_clk);
    op_a <= a;
    op_b <= b;
    sign_a <= sa;
    sign_b <= sb;
  endtask : ops

  task automatic ctl(input logic ad, cl, input logic [3:0] en, cr);
    @(posedge sys_clk);
    add_nsub <= ad;
    acc_clr <= cl;
    out_ena <= en;
    out_clr <= cr;
  endtask : ctl
endmodule : dspm_fabric

// ===== testbench/dspm_top_checker.sv
/*
  Assertions on the multiplier block ports.
  Assumes full-word control writes; keeps its own copy of the control word.
*/
`timescale 1ns/1ps
module dspm_top_checker (
  input wire logic                        sys_clk,
  input wire logic                        nrst,
  input wire logic [dspm_pkg::ADDRW-1:0]  s_axi_awaddr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [31:0]                 s_axi_wdata,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [dspm_pkg::OPW-1:0]    op_a,
  input wire logic [dspm_pkg::OPW-1:0]    op_b,
  input wire logic                        add_nsub,
  input wire logic                        acc_clr,
  input wire logic [dspm_pkg::NSET-1:0]   out_ena,
  input wire logic [dspm_pkg::NSET-1:0]   out_clr,
  input wire logic [dspm_pkg::RESW-1:0]   result,
  input wire logic                        cfg_err
);
  logic        aw_got;
  logic        w_got;
  logic        aw_ctl;
  logic [17:0] wd;
  logic [17:0] ctrl;
  logic        wr;
  logic        regd;
  assign wr   = aw_got && w_got;
  assign regd = ctrl[9] && ctrl[17:10] == 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!nrst || wr) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_got <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_got <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (s_axi_awvalid && s_axi_awready)
      aw_ctl <= s_axi_awaddr == dspm_pkg::REG_CTRL;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[17:0];
  end

  // copy lands on the same edge as the block's own control register
  always_ff @(posedge sys_clk) begin
    if (!nrst) ctrl <= 18'h0_0000;
    else if (wr && aw_ctl) ctrl <= wd;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_lane_first: assert property (
    ctrl[9:0] == 10'h000 |-> result[17:0] == op_a[8:0] * op_b[8:0])
    else $error("lane 0 product wrong");
  a_lane_last: assert property (
    ctrl[9:0] == 10'h000 |-> result[143:126] == op_a[71:63] * op_b[71:63])
    else $error("lane 7 product wrong");
  a_wide_unsigned: assert property (
    ctrl[9:0] == 10'h008 |-> result[71:0] == op_a[35:0] * op_b[35:0]
    && result[143:72] == 72'h0) else $error("wide product wrong");
  a_mix_refused: assert property (
    ctrl[3:2] == 2'h2 && ctrl[1:0] != 2'h0 |-> cfg_err)
    else $error("wide size outside simple mode accepted");
  a_err_zero: assert property (
    cfg_err && !ctrl[9] |-> result == 144'h0)
    else $error("result not zero on bad configuration");
  a_mac_step: assert property (
    ctrl[9:0] == 10'h001 && add_nsub && !acc_clr && !wr |=>
    result[51:0] == $past(result[51:0]) + $past(op_a[8:0]) * $past(op_b[8:0]))
    else $error("accumulator step wrong");
  a_reg_hold: assert property (
    regd && !out_ena[0] && !out_clr[0] && !wr |=> $stable(result))
    else $error("output register moved while disabled");
  a_reg_clear: assert property (
    regd && out_clr[0] && !wr |=> result == 144'h0)
    else $error("output register not cleared");
  a_reg_load: assert property (
    regd && ctrl[8:0] == 9'h000 && out_ena[0] && !out_clr[0] && !wr
    |=> result[17:0] == $past(op_a[8:0]) * $past(op_b[8:0]))
    else $error("output register load wrong");

  c_wide: cover property (ctrl[3:0] == 4'h8);
  c_mac: cover property (ctrl[1:0] == 2'h1 && acc_clr);
  c_err: cover property (cfg_err);
endmodule : dspm_top_checker

bind dspm_top dspm_top_checker chk_i (.sys_clk(sys_clk), .nrst(nrst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .op_a(op_a), .op_b(op_b), .add_nsub(add_nsub), .acc_clr(acc_clr),
  .out_ena(out_ena), .out_clr(out_clr), .result(result),
  .cfg_err(cfg_err));

// ===== testbench/test_dsp_multiplier_block.sv
/*
  Self-checking bench: AXI4-Lite master tasks plus fabric model calls.
  Assumes the checker is bound to dspm_top; one clock of 40 MHz.
*/
`timescale 1ns/1ps
module test_dsp_multiplier_block;
  logic         sys_clk, nrst, awvalid, awready, wvalid, wready;
  logic         bvalid, bready, arvalid, arready, rvalid, rready;
  logic         sign_a, sign_b, add_nsub, acc_clr, cfg_err;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb, out_ena, out_clr;
  logic [1:0]   bresp, rresp;
  logic [71:0]  op_a, op_b, a, b, a2;
  logic [143:0] result, x, y;
  int           miscompares, check_count, cyc, i;
  localparam logic [35:0] M = 36'hF_FFFF_FFFF;
  localparam logic [35:0] H = 36'h7_FFFF_FFFF;

  dspm_fabric fab (.sys_clk(sys_clk), .op_a(op_a), .op_b(op_b),
    .sign_a(sign_a), .sign_b(sign_b), .add_nsub(add_nsub),
    .acc_clr(acc_clr), .out_ena(out_ena), .out_clr(out_clr));
  dspm_top uut (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .op_a(op_a), .op_b(op_b), .sign_a(sign_a),
    .sign_b(sign_b), .add_nsub(add_nsub), .acc_clr(acc_clr),
    .out_ena(out_ena), .out_clr(out_clr), .result(result),
    .cfg_err(cfg_err));

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // a hang anywhere ends here instead of running forever
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [143:0] sn, ex);
    check_count++;
    if (sn !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, ex, sn);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask : wr

  task automatic rdc(input logic [7:0] ad, input logic [31:0] ed,
                     input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
  endtask : rdc

  function automatic logic [143:0] p9(input logic [71:0] pa, pb,
                                      input logic sg);
    logic [143:0] r;
    for (int k = 0; k < 8; k++) begin
      if (sg)
        r[18*k +: 18] = $signed(pa[9*k +: 9]) * $signed(pb[9*k +: 9]);
      else
        r[18*k +: 18] = pa[9*k +: 9] * pb[9*k +: 9];
    end
    return r;
  endfunction : p9

  // ea/eb are the operands after any trim to 35 bits
  task automatic w36(input logic [8:0] c, input logic [35:0] a3, b3, ea,
                     eb, input logic sa, sb, sg);
    logic [71:0] e;
    if (sg) e = $signed(ea) * $signed(eb);
    else e = ea * eb;
    wr(dspm_pkg::REG_CTRL, {23'h00_0000, c}, dspm_pkg::RESP_OKAY);
    fab.ops({36'h0, a3}, {36'h0, b3}, sa, sb);
    #5;
    chk("mul36", result, {72'h0, e});
  endtask : w36

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(dspm_pkg::REG_CTRL, 32'h0000_0000, dspm_pkg::RESP_OKAY);
    rdc(8'h14, 32'h0000_0000, dspm_pkg::RESP_DECERR);
    wr(dspm_pkg::REG_RES0, 32'h0000_0001, dspm_pkg::RESP_DECERR);
    $display("test bus done");
    for (i = 0; i < 8; i++) begin
      a[9*i +: 9] = 9'h1FF - 9'(i);
      b[9*i +: 9] = 9'h100 + 9'(i);
    end
    fab.ops(a, b, 1'b0, 1'b0);
    #5;
    x = p9(a, b, 1'b0);
    chk("simple9", result, x);
    rdc(dspm_pkg::REG_RES0, x[31:0], dspm_pkg::RESP_OKAY);
    wr(dspm_pkg::REG_CTRL, 32'h0000_0050, dspm_pkg::RESP_OKAY);
    #5;
    chk("signed9", result, p9(a, b, 1'b1));
    wr(dspm_pkg::REG_CTRL, 32'h0000_0004, dspm_pkg::RESP_OKAY);
    #5;
    for (i = 0; i < 4; i++) y[36*i +: 36] = a[18*i +: 18] * b[18*i +: 18];
    chk("simple18", result, y);
    $display("test simple done");
    w36(9'h008, M, M, M, M, 1'b0, 1'b0, 1'b0);
    w36(9'h058, M, M, M, M, 1'b0, 1'b0, 1'b1);
    w36(9'h048, 36'h8_0000_0003, M - 4, 36'h3, M - 4,
        1'b0, 1'b0, 1'b1);
    w36(9'h068, 36'h4_0000_0000, 36'h2, 36'hC_0000_0000, 36'h2,
        1'b1, 1'b0, 1'b1);
    w36(9'h0A8, M, M, H, H, 1'b0, 1'b0, 1'b0);
    w36(9'h1A8, M, M, M, M, 1'b0, 1'b1, 1'b0);
    wr(dspm_pkg::REG_CTRL, 32'h0000_000A, dspm_pkg::RESP_OKAY);
    #5;
    chk("cfg_err", cfg_err, 1'b1);
    chk("err_res", result, 144'h0);
    rdc(dspm_pkg::REG_STAT, 32'h0000_0001, dspm_pkg::RESP_OKAY);
    $display("test wide done");
    a = {8{9'h1FF}};
    for (i = 0; i < 8; i++) b[9*i +: 9] = 9'(i + 1);
    wr(dspm_pkg::REG_CTRL, 32'h0000_0002, dspm_pkg::RESP_OKAY);
    fab.ops(a, b, 1'b0, 1'b0);
    fab.ctl(1'b1, 1'b0, 4'h0, 4'h0);
    #5;
    chk("add2", result[71:0], {36'hDF9, 36'h5FD});
    fab.ctl(1'b0, 1'b0, 4'h0, 4'h0);
    #5;
    chk("sub2", result[35:0], 36'hF_FFFF_FE01);
    wr(dspm_pkg::REG_CTRL, 32'h0000_0003, dspm_pkg::RESP_OKAY);
    fab.ctl(1'b1, 1'b0, 4'h0, 4'h0);
    #5;
    chk("add4", result, {72'h33E6, 72'h13F6});
    wr(dspm_pkg::REG_CTRL, 32'h0000_0001, dspm_pkg::RESP_OKAY);
    fab.ops(72'h3, 72'h4, 1'b0, 1'b0);
    fab.ctl(1'b1, 1'b1, 4'h0, 4'h0);
    fab.ctl(1'b1, 1'b0, 4'h0, 4'h0);
    #5;
    chk("mac_clr", result, 144'hC);
    @(posedge sys_clk);
    #5;
    chk("mac_add", result, 144'h18);
    fab.ctl(1'b0, 1'b0, 4'h0, 4'h0);
    #5;
    chk("mac_add", result, 144'h24);
    @(posedge sys_clk);
    #5;
    chk("mac_sub", result, 144'h18);
    fab.ops(72'h0, 72'h0, 1'b0, 1'b0);
    rdc(dspm_pkg::REG_ACC0, 32'h0000_000C, dspm_pkg::RESP_OKAY);
    $display("test modes done");
    wr(dspm_pkg::REG_CTRL, 32'h0000_0200, dspm_pkg::RESP_OKAY);
    fab.ctl(1'b1, 1'b0, 4'h0, 4'hF);
    fab.ops(a, b, 1'b0, 1'b0);
    #5;
    chk("reg_clr", result, 144'h0);
    fab.ctl(1'b1, 1'b0, 4'h1, 4'h0);
    #5;
    chk("reg_hold", result, 144'h0);
    @(posedge sys_clk);
    #5;
    x = p9(a, b, 1'b0);
    chk("reg_load", result, x);
    fab.ctl(1'b1, 1'b0, 4'h0, 4'h0);
    wr(dspm_pkg::REG_CTRL, 32'h0000_1200, dspm_pkg::RESP_OKAY);
    a2 = {8{9'h155}};
    fab.ops(a2, a, 1'b0, 1'b0);
    fab.ctl(1'b1, 1'b0, 4'h1, 4'h0);
    @(posedge sys_clk);
    #5;
    y = p9(a2, a, 1'b0);
    chk("reg_sets", result, {y[143:72], x[71:36], y[35:0]});
    fab.ctl(1'b1, 1'b0, 4'h0, 4'h2);
    @(posedge sys_clk);
    #5;
    chk("reg_clr1", result, {y[143:72], 36'h0, y[35:0]});
    $display("test outreg done");
    wr(dspm_pkg::REG_CTRL, 32'h0000_0056, dspm_pkg::RESP_OKAY);
    fab.ops(a, b, 1'b0, 1'b0);
    #5;
    chk("add2w", result, {72'hFF_FFFF_FFFF_FFFF_E3F4,
                          72'hFF_FFFF_FFFF_FFFF_F3FC});
    rdc(dspm_pkg::REG_STAT, 32'h0000_0002, dspm_pkg::RESP_OKAY);
    wr(dspm_pkg::REG_CTRL, 32'h0000_0057, dspm_pkg::RESP_OKAY);
    #5;
    chk("add4w", result, {{9{8'hFF}}, 72'hFF_FFFF_FFFF_FFFF_D7F0});
    $display("test add18 done");
    complete_run();
  end
endmodule : test_dsp_multiplier_block
